// ### hdl/acqhp_port.v
// Purpose: processor command and register port of the acquisition control module
// Assumes: pins are asynchronous and pass two flops; words use bit 0 as msb (index 11-n)
// Notes: dma, display and converter analog side are outside; only their handshakes appear
//
// Summary of operation
// - status word one bit 1 reads 1 after count-time timer expiry.
// - real-time clock flag in status word one sets every 10 ms.
// - switch flag reads 1 while any control or erase pushbutton engaged.
// - erase flag reads 1 while erase pushbuttons engaged.
// - direction flag reads 1 when the direction switch is left.
// - status one bits 8-11 give pressed button index, bit 8 msb.
// - status word two bit 0 reads 1 on list address overflow.
// - status two bits 8-11 give the timer time-out code, bit 8 msb.
// - separate k and j transfer commands each latch their own word.
// - control bits 0-1 select memory field for storage and display.
// - control bit 2 held as storage routing control.
// - control bits 3-5 select converter address, bit 3 msb.
// - control bits 6-7 select off, accumulator, dma increment or list.
// - timer preset built from 8-bit e term and two bcd digits.
// - mode bit 8 set: one interrupt per press of upper four buttons.
// - mode bit 8 clear: held press repeats at most 50 per second.
// - mode bits 9,10,11 drive lamps c,b,a; zero lights the lamp.
// - separate commands clear real-time clock and switch interrupts.
// - list address loads from j and increments per stored 24-bit datum.
// - list full raises a processor interrupt.
// - list mode stores each event with two back-to-back dma cycles.
// - timer runs gated by live time or on clock time; interrupts when done.
// - output selector places one of eight formatted words on j or k.
// - skip request raised when marker or plotter operation finishes.
// - start-key clear resets clock control and front-panel logic.
`timescale 1ns/1ps
`include "acqhp_defines.vh"
module acqhp_port #(
   parameter RTC_CYC = `ACQHP_RTC_CYC,
   parameter REP_CYC = `ACQHP_REP_CYC,
   parameter TIMER_W = 16,
   parameter LIST_W = 12
) (
   input wire mclk,
   input wire rst_b,
   input wire start_clr,
   input wire cmd_strobe,
   input wire [11:0] cmd_code,
   input wire [11:0] acc_k,
   input wire [11:0] acc_j,
   input wire [15:0] button_pins,
   input wire erase_pins,
   input wire dir_left_pin,
   input wire live_time_pin,
   input wire converter_busy_pin,
   input wire event_valid,
   input wire [23:0] event_data,
   input wire dma_grant,
   input wire marker_plot_done,
   input wire [2:0] out_select,
   output reg [11:0] proc_j_in_q,
   output reg [11:0] proc_k_in_q,
   output reg proc_in_valid_q,
   output reg processor_interrupt_n,
   output reg skip_req_q,
   output reg [1:0] mem_field_q,
   output reg storage_route_q,
   output reg [2:0] converter_addr_q,
   output reg converter_enable_n,
   output reg [1:0] acq_mode_q,
   output reg [2:0] lamps_cba_n_q,
   output reg dma_req_q,
   output reg [LIST_W-1:0] dma_addr_q,
   output reg [11:0] dma_data_q
);
   // ==========================================
   // mode codes and list dma states
   localparam MODE_OFF = 2'b00;
   localparam MODE_ACC = 2'b01;
   localparam MODE_DMI = 2'b10;
   localparam MODE_LIST = 2'b11;
   localparam DS_IDLE = 2'b00;
   localparam DS_HI = 2'b01;
   localparam DS_LO = 2'b10;

   function [11:0] fld;
      input [11:0] w;
      integer i;
      begin
         for (i = 0; i < 12; i = i + 1) fld[i] = w[11-i];
      end
   endfunction

   function hit;
      input [11:0] c;
      input [11:0] want;
      begin
         hit = cmd_strobe && (c == want);
      end
   endfunction

   // ==========================================
   // pin synchronisers
   reg [19:0] sync1_q, sync2_q;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 20'h00000;
         sync2_q <= 20'h00000;
      end else begin
         sync1_q <= {converter_busy_pin, live_time_pin, dir_left_pin, erase_pins, button_pins};
         sync2_q <= sync1_q;
      end
   end
   wire [15:0] btn = sync2_q[15:0];
   wire erase_s = sync2_q[16];
   wire dir_s = sync2_q[17];
   wire live_s = sync2_q[18];
   wire busy_s = sync2_q[19];
   wire any_btn = |btn;

   // ==========================================
   // command decode
   wire wr_k = hit(cmd_code, `ACQHP_CMD_WR_K);
   wire wr_j = hit(cmd_code, `ACQHP_CMD_WR_J);
   wire wr_lamp = hit(cmd_code, `ACQHP_CMD_LAMP);
   wire clr_rtc = hit(cmd_code, `ACQHP_CMD_CLR_RTC);
   wire clr_sw = hit(cmd_code, `ACQHP_CMD_CLR_SW);
   wire wr_list = hit(cmd_code, `ACQHP_CMD_LIST);
   wire rd_k = hit(cmd_code, `ACQHP_CMD_RD_K);
   wire rd_j = hit(cmd_code, `ACQHP_CMD_RD_J);
   wire [11:0] kf = fld(acc_k);
   wire [11:0] jf = fld(acc_j);

   // ==========================================
   // acquisition control and timer preset
   reg [7:0] e_term_q;
   reg [7:0] bcd_q;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mem_field_q <= 2'b00;
         storage_route_q <= 1'b0;
         converter_addr_q <= 3'b000;
         converter_enable_n <= 1'b1;
         acq_mode_q <= MODE_OFF;
         e_term_q <= 8'h00;
         bcd_q <= 8'h00;
      end else begin
         if (wr_k) begin
            mem_field_q <= {kf[0], kf[1]};
            storage_route_q <= kf[2];
            converter_addr_q <= {kf[3], kf[4], kf[5]};
            converter_enable_n <= ~({kf[3], kf[4], kf[5]} == 3'b000);
            acq_mode_q <= {kf[6], kf[7]};
            e_term_q[7:4] <= {kf[8], kf[9], kf[10], kf[11]};
         end
         if (wr_j) begin
            e_term_q[3:0] <= {jf[0], jf[1], jf[2], jf[3]};
            bcd_q <= {jf[4], jf[5], jf[6], jf[7], jf[8], jf[9], jf[10], jf[11]};
         end
      end
   end

   // ==========================================
   // count-time timer: counts 10 ms ticks, gated by live time when selected
   wire rtc_tick;
   acqhp_tick #(.PERIOD(RTC_CYC), .W(24)) u_rtc (
      .mclk(mclk),
      .rst_b(rst_b),
      .clr(start_clr),
      .tick_q(rtc_tick)
   );
   reg [TIMER_W-1:0] timer_q;
   reg timer_done_q;
   reg [3:0] tmo_code_q;
   reg rtc_flag_q, tmr_irq_q;
   wire [TIMER_W-1:0] preset = {e_term_q, bcd_q};
   wire tmr_run = rtc_tick && !timer_done_q && acq_mode_q != MODE_OFF && (!live_s || !busy_s);
   wire tmr_set = !wr_j && tmr_run && timer_q <= {{(TIMER_W-1){1'b0}}, 1'b1};
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timer_q <= {TIMER_W{1'b0}};
         timer_done_q <= 1'b0;
         tmo_code_q <= 4'h0;
         rtc_flag_q <= 1'b0;
         tmr_irq_q <= 1'b0;
      end else if (start_clr) begin
         timer_q <= {TIMER_W{1'b0}};
         timer_done_q <= 1'b0;
         tmo_code_q <= 4'h0;
         rtc_flag_q <= 1'b0;
         tmr_irq_q <= 1'b0;
      end else begin
         if (rtc_tick) rtc_flag_q <= 1'b1;
         else if (clr_rtc) rtc_flag_q <= 1'b0;
         if (wr_j) begin
            timer_q <= preset;
            timer_done_q <= 1'b0;
         end else if (tmr_run) begin
            if (tmr_set) begin
               timer_done_q <= 1'b1;
               tmr_irq_q <= 1'b1;
               tmo_code_q <= {2'b00, acq_mode_q};
            end
            timer_q <= timer_q - 1'b1;
         end
         if (clr_rtc && !tmr_set) tmr_irq_q <= 1'b0; // set wins over a same-cycle clear
      end
   end

   // ==========================================
   // front panel: switch interrupt, single or repeating
   reg [11:0] lamp_mode_q;
   reg sw_irq_q, upper_prev_q;
   reg [3:0] btn_idx_q;
   reg [22:0] rep_q;
   wire upper = |btn[3:0];
   wire rep_fire = upper && !lamp_mode_q[`ACQHP_LAMP_ONCE] && rep_q == REP_CYC[22:0] - 1'b1;
   wire sw_event = (any_btn && !upper_prev_q) || erase_s || rep_fire;
   integer b;
   always @* begin
      btn_idx_q = 4'h0;
      for (b = 15; b >= 0; b = b - 1) if (btn[b]) btn_idx_q = b[3:0];
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lamp_mode_q <= `ACQHP_LAMP_RST;
         lamps_cba_n_q <= 3'b111;
         sw_irq_q <= 1'b0;
         upper_prev_q <= 1'b0;
         rep_q <= 23'h000000;
      end else if (start_clr) begin
         sw_irq_q <= 1'b0;
         upper_prev_q <= 1'b0;
         rep_q <= 23'h000000;
      end else begin
         if (wr_lamp) begin
            lamp_mode_q <= acc_j & 12'h00f;
            lamps_cba_n_q <= {jf[9], jf[10], jf[11]};
         end
         upper_prev_q <= any_btn;
         if (!upper || rep_fire) rep_q <= 23'h000000;
         else rep_q <= rep_q + 1'b1;
         if (sw_event) sw_irq_q <= 1'b1;
         else if (clr_sw) sw_irq_q <= 1'b0;
      end
   end

   // ==========================================
   // list mode: double dma per event, address counter
   reg [1:0] ds_q;
   reg [LIST_W-1:0] list_q;
   reg [11:0] lo_q;
   reg ovf_q, list_irq_q;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ds_q <= DS_IDLE;
         list_q <= {LIST_W{1'b0}};
         lo_q <= 12'h000;
         ovf_q <= 1'b0;
         list_irq_q <= 1'b0;
         dma_req_q <= 1'b0;
         dma_addr_q <= {LIST_W{1'b0}};
         dma_data_q <= 12'h000;
      end else begin
         if (wr_list) begin
            list_q <= acc_j[LIST_W-1:0];
            ovf_q <= 1'b0;
            list_irq_q <= 1'b0;
         end
         case (ds_q)
            DS_IDLE: begin
               if (event_valid && acq_mode_q == MODE_LIST && !ovf_q) begin
                  dma_req_q <= 1'b1;
                  dma_addr_q <= list_q;
                  dma_data_q <= event_data[23:12];
                  lo_q <= event_data[11:0];
                  ds_q <= DS_HI;
               end
            end
            DS_HI: begin
               if (dma_grant) begin
                  dma_data_q <= lo_q;
                  ds_q <= DS_LO;
               end
            end
            DS_LO: begin
               if (dma_grant) begin
                  dma_req_q <= 1'b0;
                  ds_q <= DS_IDLE;
                  list_q <= list_q + 1'b1;
                  if (&list_q) begin
                     ovf_q <= 1'b1;
                     list_irq_q <= 1'b1;
                  end
               end
            end
            default: ds_q <= DS_IDLE;
         endcase
      end
   end

   // ==========================================
   // status words and output selector
   reg [11:0] st1, st2, sel;
   always @* begin
      st1 = 12'h000;
      st1[`ACQHP_ST1_TFLAG] = timer_done_q;
      st1[`ACQHP_ST1_RTC] = rtc_flag_q;
      st1[`ACQHP_ST1_SW] = any_btn | erase_s;
      st1[`ACQHP_ST1_ERASE] = erase_s;
      st1[`ACQHP_ST1_DIR] = dir_s;
      st1[3:0] = btn_idx_q;
      st2 = 12'h000;
      st2[`ACQHP_ST2_OVF] = ovf_q;
      st2[3:0] = tmo_code_q;
      case (out_select)
         3'd0: sel = st1;
         3'd1: sel = st2;
         3'd2: sel = timer_q[11:0];
         3'd3: sel = {4'h0, e_term_q};
         3'd4: sel = {list_q};
         3'd5: sel = lamp_mode_q;
         3'd6: sel = {4'h0, mem_field_q, storage_route_q, converter_addr_q, acq_mode_q};
         default: sel = {8'h00, bcd_q[3:0]};
      endcase
   end
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         proc_j_in_q <= 12'h000;
         proc_k_in_q <= 12'h000;
         proc_in_valid_q <= 1'b0;
         processor_interrupt_n <= 1'b1;
         skip_req_q <= 1'b0;
      end else begin
         proc_in_valid_q <= rd_j | rd_k;
         if (rd_j) proc_j_in_q <= (out_select == 3'd0) ? st1 : sel;
         if (rd_k) proc_k_in_q <= (out_select == 3'd0) ? st2 : sel;
         processor_interrupt_n <= ~(rtc_flag_q | tmr_irq_q | sw_irq_q | list_irq_q);
         if (marker_plot_done) skip_req_q <= 1'b1;
         else if (cmd_strobe) skip_req_q <= 1'b0;
      end
   end
endmodule // acqhp_port

// ### hdl/acqhp_tick.v
// Purpose: free-running period counter giving one-cycle ticks
// Assumes: single mclk domain
// Notes: clr restarts the period
`timescale 1ns/1ps
module acqhp_tick #(
   parameter PERIOD = 1000000,
   parameter W = 24
) (
   input wire mclk,
   input wire rst_b,
   input wire clr,
   output reg tick_q
);
   reg [W-1:0] cnt_q;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= {W{1'b0}};
         tick_q <= 1'b0;
      end else if (clr) begin
         cnt_q <= {W{1'b0}};
         tick_q <= 1'b0;
      end else if (cnt_q == PERIOD[W-1:0] - 1'b1) begin
         cnt_q <= {W{1'b0}};
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end
endmodule // acqhp_tick

// ### include/acqhp_defines.vh
// Purpose: constants for the acquisition control host port
// Assumes: 12-bit processor words, 100 MHz mclk
// Notes: command codes are the low 12 bits of the i/o instruction pair
`ifndef ACQHP_DEFINES_VH
`define ACQHP_DEFINES_VH
// ==========================================
// command codes
`define ACQHP_CMD_RD_K 12'o0604
`define ACQHP_CMD_RD_J 12'o0602
`define ACQHP_CMD_WR_K 12'o2024
`define ACQHP_CMD_WR_J 12'o2022
`define ACQHP_CMD_LAMP 12'o0614
`define ACQHP_CMD_CLR_RTC 12'o0612
`define ACQHP_CMD_CLR_SW 12'o0611
`define ACQHP_CMD_LIST 12'o0624
// ==========================================
// field positions (register indices, bit 0 is the word lsb)
`define ACQHP_ST1_TFLAG 10
`define ACQHP_ST1_RTC 9
`define ACQHP_ST1_SW 8
`define ACQHP_ST1_ERASE 7
`define ACQHP_ST1_DIR 6
`define ACQHP_ST2_OVF 11
`define ACQHP_LAMP_ONCE 3
// ==========================================
// reset values
`define ACQHP_CTL_RST 12'h000
`define ACQHP_LAMP_RST 12'h00f
// ==========================================
// timing
`define ACQHP_RTC_MS 10
`define ACQHP_REP_HZ 50
`define ACQHP_CLK_HZ 100000000
`define ACQHP_RTC_CYC ((`ACQHP_CLK_HZ / 1000) * `ACQHP_RTC_MS)
`define ACQHP_REP_CYC ((`ACQHP_CLK_HZ + `ACQHP_REP_HZ - 1) / `ACQHP_REP_HZ)
`endif

// ### verif/acqhp_cpu_model.sv
// Purpose: processor i/o bus model issuing host port commands
// Assumes: drives just after the falling edge, one strobe per command
// Notes: released accumulators show inverted data, never the stale word
`timescale 1ns/1ps
module acqhp_cpu_model (
   input wire mclk,
   output logic cmd_strobe,
   output logic [11:0] cmd_code,
   output logic [11:0] acc_k,
   output logic [11:0] acc_j
);
   initial begin
      cmd_strobe = 1'b0;
      cmd_code = 12'h000;
      acc_k = 12'h000;
      acc_j = 12'h000;
   end
   // ==========================================
   // one command, k and j both driven under the same code
   task io(input logic [11:0] code, input logic [11:0] k, input logic [11:0] j);
      @(negedge mclk);
      cmd_strobe = 1'b1;
      cmd_code = code;
      acc_k = k;
      acc_j = j;
      @(negedge mclk);
      cmd_strobe = 1'b0;
      cmd_code = ~code;
      acc_k = ~k;
      acc_j = ~j;
   endtask
endmodule // acqhp_cpu_model

// ### verif/acqhp_port_checker.sv
// Purpose: port assertions for the acquisition control host port
// Assumes: single mclk domain, rst_b asynchronous active low
// Notes: bound into acqhp_port, sees its ports only
`timescale 1ns/1ps
`include "acqhp_defines.vh"
module acqhp_port_checker (
   input wire mclk,
   input wire rst_b,
   input wire cmd_strobe,
   input wire [11:0] cmd_code,
   input wire [11:0] acc_k,
   input wire [11:0] acc_j,
   input wire marker_plot_done,
   input wire [11:0] proc_j_in_q,
   input wire [11:0] proc_k_in_q,
   input wire proc_in_valid_q,
   input wire [1:0] mem_field_q,
   input wire storage_route_q,
   input wire [2:0] converter_addr_q,
   input wire [1:0] acq_mode_q,
   input wire [2:0] lamps_cba_n_q,
   input wire skip_req_q,
   input wire dma_req_q
);
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire rd_cmd = cmd_strobe && (cmd_code == `ACQHP_CMD_RD_J || cmd_code == `ACQHP_CMD_RD_K);
   wire wk_cmd = cmd_strobe && cmd_code == `ACQHP_CMD_WR_K;
   wire lamp_cmd = cmd_strobe && cmd_code == `ACQHP_CMD_LAMP;
   // ==========================================
   // assertions
   read_answer_a: assert property (rd_cmd |=> proc_in_valid_q)
      else $error("read command got no answer");
   valid_cause_a: assert property (proc_in_valid_q |-> $past(rd_cmd))
      else $error("read valid without a read command");
   read_hold_a: assert property (!proc_in_valid_q |-> $stable(proc_j_in_q) && $stable(proc_k_in_q))
      else $error("read word changed without a read");
   field_mode_a: assert property (wk_cmd |=> mem_field_q == $past(acc_k[11:10]) && acq_mode_q == $past(acc_k[5:4]))
      else $error("field or mode not loaded from k");
   addr_route_a: assert property (wk_cmd |=> converter_addr_q == $past(acc_k[8:6]) && storage_route_q == $past(acc_k[9]))
      else $error("address or routing bit not loaded from k");
   ctl_hold_a: assert property (!wk_cmd |=> $stable(acq_mode_q) && $stable(converter_addr_q))
      else $error("control word changed without its command");
   lamp_load_a: assert property (lamp_cmd |=> lamps_cba_n_q == $past(acc_j[2:0]))
      else $error("lamps not loaded from j");
   lamp_hold_a: assert property (!lamp_cmd |=> $stable(lamps_cba_n_q))
      else $error("lamps changed without their command");
   skip_raise_a: assert property (marker_plot_done |-> ##[1:4] skip_req_q)
      else $error("no skip request after marker done");
   cover property (rd_cmd ##1 proc_in_valid_q);
   cover property ($rose(dma_req_q));
   cover property ($rose(skip_req_q));
endmodule // acqhp_port_checker
bind acqhp_port acqhp_port_checker acqhp_port_checker_inst (
   .mclk(mclk), .rst_b(rst_b), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .acc_k(acc_k),
   .acc_j(acc_j), .marker_plot_done(marker_plot_done), .proc_j_in_q(proc_j_in_q),
   .proc_k_in_q(proc_k_in_q), .proc_in_valid_q(proc_in_valid_q), .mem_field_q(mem_field_q),
   .storage_route_q(storage_route_q), .converter_addr_q(converter_addr_q), .acq_mode_q(acq_mode_q),
   .lamps_cba_n_q(lamps_cba_n_q), .skip_req_q(skip_req_q), .dma_req_q(dma_req_q)
);

// ### verif/testbench.sv
// Purpose: self-checking bench for the acquisition control host port
// Assumes: rtc and repeat periods shortened through parameters
// Notes: read words are noted in a queue and checked by a watcher
`timescale 1ns/1ps
`include "acqhp_defines.vh"
module testbench;
   localparam int RTC = 400;
   localparam int REP = 40;
   typedef struct {logic is_k; logic [11:0] exp; logic [11:0] mask;} acqhp_note_t;
   acqhp_note_t notes[$];
   acqhp_note_t note;
   logic mclk = 1'b0, rst_b = 1'b0, start_clr = 1'b0, erase_pins = 1'b0, dir_left_pin = 1'b0;
   logic event_valid = 1'b0, dma_grant = 1'b0, marker_plot_done = 1'b0;
   logic live_time_pin = 1'b0, converter_busy_pin = 1'b0;
   logic [2:0] out_sel = 3'h0;
   logic [15:0] button_pins = 16'h0000;
   logic [23:0] event_data = 24'h000000;
   logic [23:0] ev;
   logic [11:0] k;
   int n_fail = 0, check_count = 0, cyc = 0, i, n, t0;
   wire cmd_strobe, proc_in_valid_q, processor_interrupt_n, skip_req_q, storage_route_q;
   wire converter_enable_n, dma_req_q;
   wire [11:0] cmd_code, acc_k, acc_j, proc_j_in_q, proc_k_in_q, dma_addr_q, dma_data_q;
   wire [1:0] mem_field_q, acq_mode_q;
   wire [2:0] converter_addr_q, lamps_cba_n_q;
   always #5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   acqhp_cpu_model acqhp_cpu_model_inst (.mclk(mclk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
      .acc_k(acc_k), .acc_j(acc_j));
   acqhp_port #(.RTC_CYC(RTC), .REP_CYC(REP)) acqhp_port_inst (.mclk(mclk), .rst_b(rst_b),
      .start_clr(start_clr), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .acc_k(acc_k), .acc_j(acc_j),
      .button_pins(button_pins), .erase_pins(erase_pins), .dir_left_pin(dir_left_pin),
      .live_time_pin(live_time_pin), .converter_busy_pin(converter_busy_pin), .event_valid(event_valid),
      .event_data(event_data), .dma_grant(dma_grant), .marker_plot_done(marker_plot_done), .out_select(out_sel),
      .proc_j_in_q(proc_j_in_q), .proc_k_in_q(proc_k_in_q), .proc_in_valid_q(proc_in_valid_q),
      .processor_interrupt_n(processor_interrupt_n), .skip_req_q(skip_req_q), .mem_field_q(mem_field_q),
      .storage_route_q(storage_route_q), .converter_addr_q(converter_addr_q),
      .converter_enable_n(converter_enable_n), .acq_mode_q(acq_mode_q), .lamps_cba_n_q(lamps_cba_n_q),
      .dma_req_q(dma_req_q), .dma_addr_q(dma_addr_q), .dma_data_q(dma_data_q));
   // ==========================================
   // shared tasks
   task check(input logic [11:0] got, input logic [11:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task rd(input logic is_k, input logic [11:0] exp, input logic [11:0] mask);
      notes.push_back('{is_k, exp, mask});
      acqhp_cpu_model_inst.io(is_k ? `ACQHP_CMD_RD_K : `ACQHP_CMD_RD_J, 12'h000, 12'h000);
   endtask
   // bounded wait for the interrupt line; a timeout ends the run
   task wait_irq(input logic lvl, input int lim);
      for (n = 0; processor_interrupt_n !== lvl; n++) begin
         @(negedge mclk);
         if (n > lim) begin
            check(12'h000, 12'h001, "interrupt wait ran out");
            finish_test();
         end
      end
   endtask
   task grant;
      @(negedge mclk);
      dma_grant = 1'b1;
      @(negedge mclk);
      dma_grant = 1'b0;
   endtask
   always @(negedge mclk) begin
      if (proc_in_valid_q === 1'b1) begin
         note = notes.pop_front();
         check((note.is_k ? proc_k_in_q : proc_j_in_q) & note.mask, note.exp & note.mask, "status word");
      end
   end
   initial begin
      #900000;
      check(12'h000, 12'h001, "run limit");
      finish_test();
   end
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'ha650));
      repeat (16) @(negedge mclk);
      rst_b = 1'b1;
      check({3'h0, processor_interrupt_n, converter_enable_n, lamps_cba_n_q, acq_mode_q, mem_field_q}, 12'h1f0, "reset");
      $display("reset test done");
      for (i = 0; i < 4; i++) begin
         ev = $urandom;
         k = {ev[11:6], i[1:0], ev[3:0]};
         acqhp_cpu_model_inst.io(`ACQHP_CMD_WR_K, k, ~k);
         check({mem_field_q, storage_route_q, converter_addr_q, acq_mode_q, 4'h0}, {k[11:4], 4'h0}, "control");
         check({11'h0, converter_enable_n}, {11'h0, k[8:6] != 3'h0}, "converter enable");
      end
      out_sel = 3'h6;
      rd(1'b0, {4'h0, k[11:4]}, 12'hfff);
      out_sel = 3'h0;
      for (i = 0; i < 8; i++) begin
         acqhp_cpu_model_inst.io(`ACQHP_CMD_LAMP, 12'h000, {8'h00, 1'b1, i[2:0]});
         check({9'h0, lamps_cba_n_q}, {9'h0, i[2:0]}, "lamps");
      end
      acqhp_cpu_model_inst.io(12'h777, 12'hfff, 12'hfff);
      check({9'h0, lamps_cba_n_q}, 12'h007, "unknown code");
      $display("write test done");
      for (i = 0; i < 6; i++) begin
         n = $urandom % 16;
         ev = $urandom;
         button_pins = 16'h0001 << n;
         dir_left_pin = ev[0];
         erase_pins = (i == 5);
         repeat (5) @(negedge mclk);
         rd(1'b0, {4'h1, erase_pins, dir_left_pin, 2'h0, n[3:0]}, 12'h9ff);
         rd(1'b1, 12'h000, 12'h7f0);
      end
      button_pins = 16'h0000;
      erase_pins = 1'b0;
      repeat (5) @(negedge mclk);
      rd(1'b0, 12'h000, 12'h9b0);
      $display("status test done");
      acqhp_cpu_model_inst.io(`ACQHP_CMD_CLR_SW, 12'h000, 12'h000);
      acqhp_cpu_model_inst.io(`ACQHP_CMD_CLR_RTC, 12'h000, 12'h000);
      wait_irq(1'b1, RTC);
      wait_irq(1'b0, RTC + 20);
      t0 = cyc;
      acqhp_cpu_model_inst.io(`ACQHP_CMD_CLR_RTC, 12'h000, 12'h000);
      wait_irq(1'b1, 5);
      wait_irq(1'b0, RTC + 20);
      check({11'h0, cyc - t0 >= RTC - 2 && cyc - t0 <= RTC + 2}, 12'h001, "rtc period");
      acqhp_cpu_model_inst.io(`ACQHP_CMD_CLR_RTC, 12'h000, 12'h000);
      wait_irq(1'b1, 5);
      button_pins = 16'h0001;
      wait_irq(1'b0, 10);
      acqhp_cpu_model_inst.io(`ACQHP_CMD_CLR_SW, 12'h000, 12'h000);
      wait_irq(1'b1, 5);
      t0 = 0;
      repeat (2 * REP) begin
         @(negedge mclk);
         t0 += (processor_interrupt_n !== 1'b1);
      end
      check(t0[11:0], 12'h000, "held press in once mode");
      button_pins = 16'h0000;
      acqhp_cpu_model_inst.io(`ACQHP_CMD_LAMP, 12'h000, 12'h000);
      button_pins = 16'h0004;
      for (i = 0; i < 2; i++) begin
         wait_irq(1'b0, 2 * REP + 10);
         t0 = cyc;
         acqhp_cpu_model_inst.io(`ACQHP_CMD_CLR_SW, 12'h000, 12'h000);
         wait_irq(1'b1, 5);
      end
      wait_irq(1'b0, 2 * REP + 10);
      check({11'h0, cyc - t0 >= REP - 2}, 12'h001, "repeat rate");
      button_pins = 16'h0000;
      repeat (3) @(negedge mclk);
      start_clr = 1'b1;
      @(negedge mclk);
      start_clr = 1'b0;
      wait_irq(1'b1, 5);
      $display("interrupt test done");
      marker_plot_done = 1'b1;
      @(negedge mclk);
      marker_plot_done = 1'b0;
      for (n = 0; n < 5 && skip_req_q !== 1'b1; n++) @(negedge mclk);
      check({11'h0, skip_req_q}, 12'h001, "skip request");
      acqhp_cpu_model_inst.io(`ACQHP_CMD_LIST, 12'h000, 12'h010);
      acqhp_cpu_model_inst.io(`ACQHP_CMD_WR_K, 12'h030, 12'h000);
      for (i = 0; i < 3; i++) begin
         if (i == 2) acqhp_cpu_model_inst.io(`ACQHP_CMD_LIST, 12'h000, 12'hfff);
         ev = $urandom;
         event_data = ev;
         event_valid = 1'b1;
         for (n = 0; n < 20 && dma_req_q !== 1'b1; n++) @(negedge mclk);
         event_valid = 1'b0;
         check(dma_addr_q, (i == 2) ? 12'hfff : 12'h010 + i[11:0], "list address");
         check(dma_data_q, ev[23:12], "first dma word");
         grant();
         for (n = 0; n < 10 && !(dma_req_q === 1'b1 && dma_data_q === ev[11:0]); n++) @(negedge mclk);
         check(dma_data_q, ev[11:0], "second dma word");
         grant();
         repeat (4) @(negedge mclk);
      end
      rd(1'b1, 12'h800, 12'h800);
      check({11'h0, processor_interrupt_n}, 12'h000, "list full interrupt");
      $display("list test done");
      live_time_pin = 1'b1;
      converter_busy_pin = 1'b1;
      acqhp_cpu_model_inst.io(`ACQHP_CMD_WR_J, 12'h000, 12'h002);
      repeat (2 * RTC + 10) @(negedge mclk);
      rd(1'b0, 12'h000, 12'h400);
      converter_busy_pin = 1'b0;
      repeat (2 * RTC + 10) @(negedge mclk);
      rd(1'b0, 12'h400, 12'h400);
      rd(1'b1, 12'h003, 12'h00f);
      $display("timer test done");
      finish_test();
   end
endmodule // testbench
